// *** shared/mapper_ctrl_pkg.sv ***
// Constants for the mapper mode and line control registers.
// Assumes a byte-wide microprocessor port with one address byte.
package mapper_ctrl_pkg;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] FORMAT_POSITION_RATE_CONTROL = 8'hc0;
    localparam logic [7:0] LINE_CODING_LOOPBACK_CONTROL = 8'hc1;

    // ==========================================================
    // Field positions of format_position_rate_control
    // ==========================================================
    localparam int TRIBUTARY_GROUP_FORMAT_SEL_BIT = 7;
    localparam int TRIPLE_FRAME_FORMAT_SEL_BIT    = 6;
    localparam int DROP_SLOT_SELECT_HI            = 5;
    localparam int DROP_SLOT_SELECT_LO            = 4;
    localparam int ADD_SLOT_SELECT_HI             = 3;
    localparam int ADD_SLOT_SELECT_LO             = 2;
    localparam int FORMAT_TEST_BIT                = 1;
    localparam int RATE_SELECT_BIT                = 0;

    // ==========================================================
    // Field positions of line_coding_loopback_control
    // ==========================================================
    localparam int TX_DECODE_EN_BIT           = 7;
    localparam int RX_CODE_EN_BIT             = 6;
    localparam int TX_LINE_CLK_INVERT_BIT     = 5;
    localparam int RX_LINE_CLK_INVERT_BIT     = 4;
    localparam int RING_MODE_BIT              = 3;
    localparam int FACILITY_LOOPBACK_EN_BIT   = 2;
    localparam int LINE_LOOPBACK_EN_BIT       = 1;

    // ==========================================================
    // Encodings
    // ==========================================================
    localparam logic [1:0] BUS_FORMAT_STS1     = 2'h0;
    localparam logic [1:0] BUS_FORMAT_TRIPLE_FRAME_FORMAT_SEL     = 2'h1;
    localparam logic [1:0] BUS_FORMAT_RESERVED = 2'h2;
    localparam logic [1:0] BUS_FORMAT_TRIBUTARY_GROUP_FORMAT_SEL     = 2'h3;
    localparam logic [1:0] SLOT_A              = 2'h0;
    localparam logic [1:0] SLOT_B              = 2'h1;
    localparam logic [1:0] SLOT_C              = 2'h2;
    localparam logic [1:0] SLOT_IDLE           = 2'h3;
    localparam logic       RATE_E3             = 1'h0;
    localparam logic       RATE_DS3            = 1'h1;

    // G1 layout: far-end block error count in the upper nibble, defect flag below it.
    localparam int G1_FEBE_HI = 7;
    localparam int G1_FEBE_LO = 4;
    localparam int G1_RDI_BIT = 3;

    // Local alarm vector positions.
    localparam int ALM_POINTER_LOSS  = 0;
    localparam int ALM_PATH_AIS      = 1;
    localparam int ALM_DROP_J1_LOSS  = 2;
    localparam int ALM_BYTE_AIS      = 3;
    localparam int ALM_STATUS_LEAD   = 4;
    localparam int ALM_PATH_AIS_LEAD = 5;
    localparam int ALM_LABEL_MISMATCH = 6;
    localparam int ALM_UNEQUIPPED    = 7;
    localparam int ALM_WIDTH         = 8;

    // Values shown while in reset.
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] G1_RESET    = 8'h00;

endpackage : mapper_ctrl_pkg

// *** shared/ring_alarm_if.sv ***
// Carries ring-mode alarm signals between the control top and the G1 forwarder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ring_alarm_if;
    logic                                 ring_mode;
    logic                                 external_alarm_source_sel;
    logic                                 label_error_alarm_en;
    logic [mapper_ctrl_pkg::ALM_WIDTH-1:0] alarms;
    logic [3:0]                           partner_febe;
    logic                                 partner_rdi;
    logic                                 ext_g1_sel;
    logic [7:0]                           poh_g1;
    logic [7:0]                           internal_g1;
    logic [7:0]                           tx_g1;
    logic                                 rdi_request;

    modport ctrl (
        output ring_mode, external_alarm_source_sel, label_error_alarm_en, alarms,
        output partner_febe, partner_rdi, ext_g1_sel, poh_g1, internal_g1,
        input  tx_g1, rdi_request
    );
    modport fwd (
        input  ring_mode, external_alarm_source_sel, label_error_alarm_en, alarms,
        input  partner_febe, partner_rdi, ext_g1_sel, poh_g1, internal_g1,
        output tx_g1, rdi_request
    );
endinterface : ring_alarm_if
`default_nettype wire

// *** verilog/ring_alarm_forward.sv ***
// Chooses the outgoing G1 byte and forms the defect request for a partner device.
// Assumes the caller registers both results.
`timescale 1ns/1ps
`default_nettype none
module ring_alarm_forward (
    ring_alarm_if.fwd port
);
    // ==========================================================
    // G1 source and defect request
    // ==========================================================
    logic ext_alarm;
    logic label_alarm;

    always_comb begin
        ext_alarm = port.external_alarm_source_sel
                    ? (port.alarms[mapper_ctrl_pkg::ALM_STATUS_LEAD]
                       | port.alarms[mapper_ctrl_pkg::ALM_PATH_AIS_LEAD])
                    : port.alarms[mapper_ctrl_pkg::ALM_BYTE_AIS]; // [RULE15]
        label_alarm = port.label_error_alarm_en
                      & (port.alarms[mapper_ctrl_pkg::ALM_LABEL_MISMATCH]
                         | port.alarms[mapper_ctrl_pkg::ALM_UNEQUIPPED]); // [RULE15]
        port.rdi_request = port.alarms[mapper_ctrl_pkg::ALM_POINTER_LOSS]
                           | port.alarms[mapper_ctrl_pkg::ALM_PATH_AIS]
                           | port.alarms[mapper_ctrl_pkg::ALM_DROP_J1_LOSS]
                           | ext_alarm | label_alarm; // [RULE15]
        port.tx_g1 = port.internal_g1;
        if (port.ring_mode) begin
            port.tx_g1[mapper_ctrl_pkg::G1_FEBE_HI:mapper_ctrl_pkg::G1_FEBE_LO] =
                port.partner_febe; // [RULE13]
            port.tx_g1[mapper_ctrl_pkg::G1_RDI_BIT] = port.partner_rdi; // [RULE13]
            if (port.ext_g1_sel) begin
                port.tx_g1 = port.poh_g1; // [RULE14]
            end
        end
    end
endmodule : ring_alarm_forward
`default_nettype wire

// *** verilog/mapper_mode_and_line_control.sv ***
// Mode and line control registers of the DS3/E3 mapper, with the line-side
// coder, decoder, clock edge selection, loopbacks and ring alarm forwarding.
// Assumes line clocks arrive as levels synchronous to i_clk and well below its rate.
//
// Summary of operation
// [RULE1] The control registers load no default at power-up and hold unknown values until written.
// [RULE2] Neither hardware nor software reset changes a written control bit.
// [RULE3] The host writes every control bit after power-up before relying on the mapper.
// [RULE4] Bits 7 and 6 of the first register pick STS-1, STS-3 or TUG-3, with code 10 reserved.
// [RULE5] Bits 5 and 4 pick the dropped slot A, B or C, and code 11 idles and resets the receiver.
// [RULE6] Bits 3 and 2 pick the added slot A, B or C, and code 11 is undefined.
// [RULE7] Software writes zero to the test bit 1 of the first register.
// [RULE8] Bit 0 of the first register selects E3 mapping at 0 and DS3 mapping at 1.
// [RULE9] Transmit decoder enable at 1 decodes rail input, at 0 takes NRZ input directly.
// [RULE10] Receive coder enable at 1 drives coded rails, at 0 drives NRZ.
// [RULE11] Transmit clock invert at 0 samples on rising line clock edges, at 1 on falling ones.
// [RULE12] Receive clock invert at 0 launches data on falling clock edges, at 1 on rising ones.
// [RULE13] Ring mode puts the partner's error count and defect flag into the sent G1 byte.
// [RULE14] In ring mode with external G1 chosen, G1 comes from the overhead port.
// [RULE15] The defect request for a partner is formed from pointer loss, path AIS, J1 loss and selected alarms.
// [RULE16] Facility loopback returns transmit line data and clock as receive line data and clock.
// [RULE17] Line loopback feeds the receive line signal into the transmit path, still driving the receive pins.
`timescale 1ns/1ps
`default_nettype none
module mapper_mode_and_line_control (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Microprocessor port
    input  wire logic [7:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    output var  logic [7:0] o_rdata,
    // Decoded mode controls
    output var  logic       o_tributary_group_format_sel,
    output var  logic       o_triple_frame_format_sel,
    output var  logic [1:0] o_drop_slot_select,
    output var  logic [1:0] o_add_slot_select,
    output var  logic       o_rx_front_reset,
    output var  logic       o_ds3_mode,
    output var  logic       o_ring_mode,
    output var  logic       o_facility_loopback_en,
    output var  logic       o_line_loopback_en,
    // Transmit line input and mapper side
    input  wire logic       i_tx_line_clock,
    input  wire logic       i_tx_pos,
    input  wire logic       i_tx_neg,
    output var  logic       o_tx_path_data,
    output var  logic       o_tx_path_strobe,
    // Receive mapper side and line output
    input  wire logic       i_rx_path_clock,
    input  wire logic       i_rx_path_data,
    output var  logic       o_rx_line_clock,
    output var  logic       o_rx_pos,
    output var  logic       o_rx_neg,
    // Ring alarm interface
    input  wire logic       i_external_alarm_source_sel,
    input  wire logic       i_label_error_alarm_en,
    input  wire logic [7:0] i_alarms,
    input  wire logic [3:0] i_partner_febe,
    input  wire logic       i_partner_rdi,
    input  wire logic       i_ext_g1_sel,
    input  wire logic [7:0] i_poh_g1,
    input  wire logic [7:0] i_internal_g1,
    output var  logic [7:0] o_tx_g1,
    output var  logic       o_rdi_request
);
    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [7:0] format_position_rate_control;
        logic [7:0] line_coding_loopback_control;
        logic       rx_front_reset;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic       tx_clk_prev;
        logic       tx_data;
        logic       tx_strobe;
        logic       rx_clk;
        logic       rx_pos;
        logic       rx_neg;
        logic       mark_polarity;
        logic [7:0] tx_g1;
        logic       rdi_request;
    } state_t;

    ctrl_t  ctrl;
    ctrl_t  next_ctrl;
    state_t state;
    state_t next_state;

    ring_alarm_if ring ();

    // ==========================================================
    // Field views of the control registers
    // ==========================================================
    logic       tx_decode_en;
    logic       rx_code_en;
    logic       tx_line_clk_invert;
    logic       rx_line_clk_invert;
    logic       facility_loopback_en;
    logic       line_loopback_en;

    assign tx_decode_en = ctrl.line_coding_loopback_control[mapper_ctrl_pkg::TX_DECODE_EN_BIT];
    assign rx_code_en   = ctrl.line_coding_loopback_control[mapper_ctrl_pkg::RX_CODE_EN_BIT];
    assign tx_line_clk_invert =
        ctrl.line_coding_loopback_control[mapper_ctrl_pkg::TX_LINE_CLK_INVERT_BIT];
    assign rx_line_clk_invert =
        ctrl.line_coding_loopback_control[mapper_ctrl_pkg::RX_LINE_CLK_INVERT_BIT];
    assign facility_loopback_en =
        ctrl.line_coding_loopback_control[mapper_ctrl_pkg::FACILITY_LOOPBACK_EN_BIT];
    assign line_loopback_en =
        ctrl.line_coding_loopback_control[mapper_ctrl_pkg::LINE_LOOPBACK_EN_BIT];

    // ==========================================================
    // Ring alarm forwarding
    // ==========================================================
    assign ring.ring_mode =
        ctrl.line_coding_loopback_control[mapper_ctrl_pkg::RING_MODE_BIT];
    assign ring.external_alarm_source_sel = i_external_alarm_source_sel;
    assign ring.label_error_alarm_en      = i_label_error_alarm_en;
    assign ring.alarms                    = i_alarms;
    assign ring.partner_febe              = i_partner_febe;
    assign ring.partner_rdi               = i_partner_rdi;
    assign ring.ext_g1_sel                = i_ext_g1_sel;
    assign ring.poh_g1                    = i_poh_g1;
    assign ring.internal_g1               = i_internal_g1;

    ring_alarm_forward u_ring_alarm_forward (
        .port (ring.fwd)
    );

    // ==========================================================
    // Next-state logic
    // ==========================================================
    logic tx_clk_src;
    logic tx_pos_src;
    logic tx_neg_src;
    logic tx_edge;
    logic rx_launch;
    logic rx_data_src;

    always_comb begin
        next_ctrl  = ctrl;
        next_state = state;

        // Register writes; control bits are never touched by reset.
        if (i_wr) begin
            if (i_addr == mapper_ctrl_pkg::FORMAT_POSITION_RATE_CONTROL) begin
                next_ctrl.format_position_rate_control = i_wdata;
                next_ctrl.rx_front_reset = (i_wdata[mapper_ctrl_pkg::DROP_SLOT_SELECT_HI:
                    mapper_ctrl_pkg::DROP_SLOT_SELECT_LO] == mapper_ctrl_pkg::SLOT_IDLE); // [RULE5]
            end
            if (i_addr == mapper_ctrl_pkg::LINE_CODING_LOOPBACK_CONTROL) begin
                next_ctrl.line_coding_loopback_control = i_wdata;
            end
        end

        // Read data; other addresses answer zero.
        if (i_rd) begin
            if (i_addr == mapper_ctrl_pkg::FORMAT_POSITION_RATE_CONTROL) begin
                next_state.rdata = ctrl.format_position_rate_control;
            end else if (i_addr == mapper_ctrl_pkg::LINE_CODING_LOOPBACK_CONTROL) begin
                next_state.rdata = ctrl.line_coding_loopback_control;
            end else begin
                next_state.rdata = mapper_ctrl_pkg::RDATA_RESET;
            end
        end

        // Transmit line source: the pins, or the receive output when looped.
        if (line_loopback_en) begin
            tx_clk_src = state.rx_clk; // [RULE17]
            tx_pos_src = state.rx_pos; // [RULE17]
            tx_neg_src = state.rx_neg; // [RULE17]
        end else begin
            tx_clk_src = i_tx_line_clock;
            tx_pos_src = i_tx_pos;
            tx_neg_src = i_tx_neg;
        end
        next_state.tx_clk_prev = tx_clk_src;
        tx_edge = tx_line_clk_invert ? (state.tx_clk_prev & ~tx_clk_src)
                                     : (~state.tx_clk_prev & tx_clk_src); // [RULE11]
        next_state.tx_strobe = tx_edge;
        if (tx_edge) begin
            next_state.tx_data = tx_decode_en ? (tx_pos_src | tx_neg_src)
                                              : tx_pos_src; // [RULE9]
        end

        // Receive line output: mapper clock, or the transmit pins when looped.
        next_state.rx_clk = facility_loopback_en ? i_tx_line_clock
                                                 : i_rx_path_clock; // [RULE16]
        rx_launch = (next_state.rx_clk != state.rx_clk)
                    && (next_state.rx_clk == rx_line_clk_invert); // [RULE12]
        rx_data_src = i_rx_path_data;
        if (facility_loopback_en) begin
            next_state.rx_pos = i_tx_pos; // [RULE16]
            next_state.rx_neg = i_tx_neg; // [RULE16]
        end else if (rx_launch) begin
            if (rx_code_en) begin
                // Alternate mark polarity across the two rails.
                next_state.rx_pos = rx_data_src & ~state.mark_polarity; // [RULE10]
                next_state.rx_neg = rx_data_src & state.mark_polarity; // [RULE10]
                next_state.mark_polarity = state.mark_polarity ^ rx_data_src;
            end else begin
                next_state.rx_pos = rx_data_src; // [RULE10]
                next_state.rx_neg = 1'h0;
            end
        end

        next_state.tx_g1       = ring.tx_g1;
        next_state.rdi_request = ring.rdi_request;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge i_clk) begin
        ctrl <= next_ctrl; // [RULE1] [RULE2]
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign o_rdata = state.rdata;
    assign o_tributary_group_format_sel =
        ctrl.format_position_rate_control[mapper_ctrl_pkg::TRIBUTARY_GROUP_FORMAT_SEL_BIT]; // [RULE4]
    assign o_triple_frame_format_sel =
        ctrl.format_position_rate_control[mapper_ctrl_pkg::TRIPLE_FRAME_FORMAT_SEL_BIT]; // [RULE4]
    assign o_drop_slot_select = ctrl.format_position_rate_control[
        mapper_ctrl_pkg::DROP_SLOT_SELECT_HI:mapper_ctrl_pkg::DROP_SLOT_SELECT_LO]; // [RULE5]
    assign o_rx_front_reset = ctrl.rx_front_reset; // [RULE5]
    assign o_add_slot_select = ctrl.format_position_rate_control[
        mapper_ctrl_pkg::ADD_SLOT_SELECT_HI:mapper_ctrl_pkg::ADD_SLOT_SELECT_LO]; // [RULE6]
    assign o_ds3_mode =
        ctrl.format_position_rate_control[mapper_ctrl_pkg::RATE_SELECT_BIT]; // [RULE8]
    assign o_ring_mode            = ring.ring_mode;
    assign o_facility_loopback_en = facility_loopback_en;
    assign o_line_loopback_en     = line_loopback_en;
    assign o_tx_path_data         = state.tx_data;
    assign o_tx_path_strobe       = state.tx_strobe;
    assign o_rx_line_clock        = state.rx_clk;
    assign o_rx_pos               = state.rx_pos;
    assign o_rx_neg               = state.rx_neg;
    assign o_tx_g1                = state.tx_g1;
    assign o_rdi_request          = state.rdi_request;

endmodule : mapper_mode_and_line_control
`default_nettype wire

// *** test/mapper_ctrl_assertions.sv ***
// Port-level checks for the mapper mode and line control block.
// Assumes a bind to every instance of that block, port names unchanged.
`timescale 1ns/1ps
`default_nettype none
module mapper_ctrl_assertions (
    // Clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    // Decoded controls and line signals
    input wire logic       o_tributary_group_format_sel,
    input wire logic       o_triple_frame_format_sel,
    input wire logic [1:0] o_drop_slot_select,
    input wire logic [1:0] o_add_slot_select,
    input wire logic       o_rx_front_reset,
    input wire logic       o_ds3_mode,
    input wire logic       o_ring_mode,
    input wire logic       o_facility_loopback_en,
    input wire logic       o_line_loopback_en,
    input wire logic       i_tx_line_clock,
    input wire logic       o_rx_line_clock,
    // Ring alarms
    input wire logic       i_external_alarm_source_sel,
    input wire logic       i_label_error_alarm_en,
    input wire logic [7:0] i_alarms,
    input wire logic [3:0] i_partner_febe,
    input wire logic       i_partner_rdi,
    input wire logic       i_ext_g1_sel,
    input wire logic [7:0] i_poh_g1,
    input wire logic [7:0] i_internal_g1,
    input wire logic [7:0] o_tx_g1,
    input wire logic       o_rdi_request
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // Assertions
    // ==========
    a_write_c0_fields: assert property (i_wr && i_addr == 8'hc0 |=>
        {o_tributary_group_format_sel, o_triple_frame_format_sel, o_drop_slot_select,
         o_add_slot_select, o_ds3_mode} == {$past(i_wdata[7:2]), $past(i_wdata[0])})
        else $error("c0 write not seen on controls");
    a_write_c1_fields: assert property (i_wr && i_addr == 8'hc1 |=>
        {o_ring_mode, o_facility_loopback_en, o_line_loopback_en} == $past(i_wdata[3:1]))
        else $error("c1 write not seen on controls");
    a_write_then_read: assert property (i_wr && i_addr == 8'hc1 ##1
        i_rd && !i_wr && i_addr == 8'hc1 |=> o_rdata == $past(i_wdata, 2))
        else $error("c1 readback differs from write");
    a_unmapped_read: assert property (i_rd && !i_wr && i_addr != 8'hc0 && i_addr != 8'hc1
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_idle_front_reset: assert property (o_drop_slot_select == 2'h3 |-> o_rx_front_reset)
        else $error("idle drop code without front reset");
    a_ring_g1_insert: assert property (o_ring_mode && !i_ext_g1_sel |=>
        o_tx_g1[7:3] == $past({i_partner_febe, i_partner_rdi})) else $error("ring g1 wrong");
    a_ring_ext_g1: assert property (o_ring_mode && i_ext_g1_sel |=>
        o_tx_g1 == $past(i_poh_g1)) else $error("external g1 not used");
    a_rdi_request_mix: assert property (1'b1 |=> o_rdi_request == $past(
        i_alarms[0] | i_alarms[1] | i_alarms[2] | (i_label_error_alarm_en & (i_alarms[6] |
        i_alarms[7])) | (i_external_alarm_source_sel ? i_alarms[4] | i_alarms[5] : i_alarms[3])))
        else $error("rdi request wrong");
    a_facility_clock_copy: assert property (o_facility_loopback_en |=>
        o_rx_line_clock == $past(i_tx_line_clock)) else $error("facility clock not copied");
    c_ring_febe: cover property (o_ring_mode && i_partner_febe != 4'h0);
    c_front_reset: cover property (o_rx_front_reset);
    c_unmapped_read: cover property (i_rd && i_addr == 8'hc2);
endmodule : mapper_ctrl_assertions
bind mapper_mode_and_line_control mapper_ctrl_assertions u_chk (.*);
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the mapper mode and line control registers.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========
    // Signals
    // ==========
    logic       i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tx_line_clock = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_alarms = 8'h00, i_poh_g1 = 8'h00;
    logic       i_tx_pos = 1'b0, i_tx_neg = 1'b1, i_rx_path_clock = 1'b0, i_rx_path_data = 1'b0;
    logic       i_external_alarm_source_sel = 1'b0, i_label_error_alarm_en = 1'b0;
    logic       i_partner_rdi = 1'b0, i_ext_g1_sel = 1'b0;
    logic [7:0] i_internal_g1 = 8'h00, o_rdata, o_tx_g1, v;
    logic [3:0] i_partner_febe = 4'h0;
    logic       o_tributary_group_format_sel, o_triple_frame_format_sel, o_rx_front_reset;
    logic [1:0] o_drop_slot_select, o_add_slot_select, r1, r2;
    logic       o_ds3_mode, o_ring_mode, o_facility_loopback_en, o_line_loopback_en;
    logic       o_tx_path_data, o_tx_path_strobe, o_rx_line_clock, o_rx_pos, o_rx_neg;
    logic       o_rdi_request, e;
    int         err_count = 0, n_tests = 0, cycles = 0, s1, s2;
    logic [7:0] txc [3] = '{8'h80, 8'ha0, 8'h04};
    logic [7:0] txe [6] = '{8'h03, 8'h00, 8'h00, 8'h03, 8'h02, 8'h00};

    mapper_mode_and_line_control u_dut (.*);

    always #20 i_clk = ~i_clk;
    // ==========
    // Tasks
    // ==========
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    // Calls start and end at a falling edge, so a write may be followed by a read at once.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        i_addr = a;
        i_rd = 1'b1;
        @(negedge i_clk);
        i_rd = 1'b0;
        chk(o_rdata, exp, what);
    endtask : rd
    task automatic tx_try(input logic lvl, input logic [7:0] exp);
        int s;
        logic d;
        s = 0;
        d = 1'b0;
        i_tx_line_clock = lvl;
        repeat (3) begin
            @(negedge i_clk);
            if (o_tx_path_strobe === 1'b1) begin
                s++;
                d = o_tx_path_data;
            end
        end
        chk({5'h0, 2'(s), d}, exp, "tx strobe and data");
    endtask : tx_try
    // One mark on the receive path: clock high for three cycles, then low for three.
    task automatic rx_bit(output logic [1:0] rails, output int strobes);
        strobes = 0;
        i_rx_path_data = 1'b1;
        for (int k = 0; k < 6; k++) begin
            i_rx_path_clock = (k < 3);
            @(negedge i_clk);
            strobes += int'(o_tx_path_strobe === 1'b1);
        end
        rails = {o_rx_pos, o_rx_neg};
    endtask : rx_bit
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            finish_test();
        end
    end
    // ==========
    // Main sequence
    // ==========
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        rd(8'hc0, 8'hxx, "unwritten c0");
        for (int m = 0; m < 4; m++) begin
            v = {m[1:0], m[1:0], 2'(3 - m), 1'b0, m[0]};
            wr(8'hc0, v);
            chk({o_tributary_group_format_sel, o_triple_frame_format_sel, o_drop_slot_select,
                 o_add_slot_select, 1'b0, o_ds3_mode}, v, "c0 fields");
            chk({7'h0, o_rx_front_reset}, {7'h0, m == 3}, "front reset");
            rd(8'hc0, v, "c0 read");
        end
        wr(8'hc1, 8'h5b);
        rd(8'hc1, 8'h5b, "c1 read");
        chk({5'h0, o_ring_mode, o_facility_loopback_en, o_line_loopback_en}, 8'h05, "c1");
        wr(8'hc2, 8'hff);
        rd(8'hc2, 8'h00, "unmapped read");
        cyc(1);
        rd(8'hc1, 8'h5b, "c1 after unmapped write");
        wr(8'hc0, 8'h35);
        i_rst_n = 1'b0;
        cyc(3);
        i_rst_n = 1'b1;
        rd(8'hc0, 8'h35, "c0 after reset");
        cyc(1);
        rd(8'hc1, 8'h5b, "c1 after reset");
        for (int k = 0; k < 3; k++) begin
            wr(8'hc1, txc[k]);
            tx_try(1'b1, txe[2 * k]);
            tx_try(1'b0, txe[2 * k + 1]);
        end
        chk({5'h0, o_rx_line_clock, o_rx_pos, o_rx_neg}, 8'h01, "facility loop");
        wr(8'hc1, 8'h42);
        rx_bit(r1, s1);
        rx_bit(r2, s2);
        chk({4'h0, r1, r2}, 8'h09, "coded marks alternate");
        chk({7'h0, s1 > 0 && s2 > 0}, 8'h01, "line loopback strobes");
        chk({7'h0, o_rx_line_clock}, 8'h00, "rx clock still driven");
        wr(8'hc1, 8'h00);
        rx_bit(r1, s1);
        chk({6'h0, r1}, 8'h02, "nrz rails");
        wr(8'hc1, 8'h10);
        i_rx_path_data = 1'b0;
        i_rx_path_clock = 1'b1;
        cyc(2);
        chk({6'h0, o_rx_pos, o_rx_neg}, 8'h00, "rising launch");
        wr(8'hc1, 8'h08);
        i_partner_febe = 4'h9;
        i_partner_rdi = 1'b1;
        i_internal_g1 = 8'h5a;
        i_poh_g1 = 8'hc3;
        cyc(2);
        chk(o_tx_g1, 8'h9a, "ring g1");
        i_ext_g1_sel = 1'b1;
        cyc(2);
        chk(o_tx_g1, 8'hc3, "external g1");
        wr(8'hc1, 8'h00);
        cyc(2);
        chk(o_tx_g1, 8'h5a, "internal g1");
        for (int m = 0; m < 32; m++) begin
            i_alarms = 8'h01 << m[2:0];
            i_external_alarm_source_sel = m[3];
            i_label_error_alarm_en = m[4];
            e = (m[2:0] < 3) || (m[2:0] == 3 && !m[3]) || (m[2:0] > 5 && m[4])
                || ((m[2:0] == 4 || m[2:0] == 5) && m[3]);
            cyc(2);
            chk({7'h0, o_rdi_request}, {7'h0, e}, "rdi request");
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
